// ==== hlc_pkg.sv ====
// Shared constants for the level control and output volume gain path.
package hlc_pkg;
  // Control port addresses of the manual level gain registers.
  localparam logic [7:0] ADDR_LEFT_GAIN = 8'h09;
  localparam logic [7:0] ADDR_RIGHT_GAIN = 8'h0C;
  // Level gain code for 0 dB, also the reset value of both gain registers.
  localparam logic [7:0] LEVEL_GAIN_UNITY = 8'h91;
  // Sample width and fraction bits of the gain mantissas.
  localparam int SAMPLE_W = 24;
  localparam int MANT_FRAC = 14;
  // Level gain mantissas, 2^(k/16) for 0.375 dB codes within one octave.
  localparam logic [15:0] LEVEL_MANT [16] = '{
    16'h4000, 16'h42D5, 16'h45CB, 16'h48E2, 16'h4C1C, 16'h4F7B, 16'h52FF,
    16'h56AC, 16'h5A82, 16'h5E84, 16'h62B4, 16'h6712, 16'h6BA2, 16'h7066,
    16'h7560, 16'h7A93};
  // Output volume mantissas, 2^(-k/12) for 0.5 dB codes within one octave.
  localparam logic [15:0] VOL_MANT [12] = '{
    16'h4000, 16'h3C68, 16'h3904, 16'h35D1, 16'h32CC, 16'h2FF2, 16'h2D41,
    16'h2AB7, 16'h2851, 16'h260E, 16'h23EB, 16'h21E7};
  // Output volume codes per octave and the boost shift of code zero.
  localparam int VOL_CODES_PER_OCT = 12;
  localparam int VOL_BOOST_SHIFT = 2;
  localparam logic [7:0] VOL_MUTE_CODE = 8'hFF;
  // Ramp resolution: fine levels per volume code and ramp step sizes.
  localparam int VOL_FINE_SHIFT = 2;
  localparam logic [9:0] VOL_STEP_SLOW = 10'h001;
  localparam logic [9:0] VOL_STEP_FAST = 10'h004;
  // Timer bases in sample periods, scaled up by the select fields.
  localparam logic [10:0] ZC_TIMEOUT_BASE = 11'h080;
  localparam logic [14:0] WAIT_BASE = 15'h0080;
  // Gain deficit in codes beyond which recovery counts as fast recovery.
  localparam logic [8:0] FAST_GAP = 9'h010;
  // Limiter detection levels as sample magnitudes.
  localparam logic [23:0] LIMIT_LEVEL [4] = '{
    24'h65_AC8C, 24'h5A_9DF7, 24'h50_C335, 24'h47_FACD};
  // Reset level lies the detection level shifted right by this many bits, one eighth, below it.
  localparam int RESET_LEVEL_SHIFT = 3;
  // De-emphasis select code that enables the filter.
  localparam logic [1:0] DEEMPH_ON = 2'b01;
  // De-emphasis filter coefficients, fraction of MANT_FRAC bits.
  localparam logic signed [15:0] DEEMPH_B0 = 16'sh1D68;
  localparam logic signed [15:0] DEEMPH_B1 = -16'sh086F;
  localparam logic signed [15:0] DEEMPH_A1 = 16'sh2B07;
endpackage

// ==== hlc_zc_gate.sv ====
// Zero-cross gated gain follower for one channel.
`timescale 1ns/1ps
`default_nettype none
module hlc_zc_gate (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic tick_i,
  input wire logic sample_sign_i,
  input wire logic [7:0] target_i,
  input wire logic restart_i,
  input wire logic immediate_i,
  input wire logic [10:0] timeout_i,
  output logic [7:0] gain_o
);
  logic [10:0] zc_cnt;
  logic last_sign;

  // Gain follows the target at a sign change, at timeout or at once.
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      gain_o <= hlc_pkg::LEVEL_GAIN_UNITY;
      zc_cnt <= 11'h000;
      last_sign <= 1'b0;
    end
    else if (restart_i)
    begin
      zc_cnt <= 11'h000;
    end
    else if (tick_i)
    begin
      last_sign <= sample_sign_i;
      if (gain_o == target_i)
      begin
        zc_cnt <= 11'h000;
      end
      else if (immediate_i || (sample_sign_i != last_sign) ||
               (zc_cnt + 11'h001 >= timeout_i))
      begin
        gain_o <= target_i;
        zc_cnt <= 11'h000;
      end
      else
      begin
        zc_cnt <= zc_cnt + 11'h001;
      end
    end
  end
endmodule
`default_nettype wire

// ==== hlc_vol_ramp.sv ====
// Soft transition ramp of one output volume channel, with soft mute.
`timescale 1ns/1ps
`default_nettype none
module hlc_vol_ramp (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic tick_i,
  input wire logic [7:0] target_code_i,
  input wire logic mute_i,
  input wire logic fast_i,
  output logic [7:0] code_o
);
  logic [9:0] fine;
  logic [9:0] goal;
  logic [9:0] step;

  // Mute aims at the mute code, so releasing it mid-ramp turns back.
  always_comb
  begin
    goal = mute_i ? {hlc_pkg::VOL_MUTE_CODE, 2'b00} :
                    {target_code_i, 2'b00};
    step = fast_i ? hlc_pkg::VOL_STEP_FAST : hlc_pkg::VOL_STEP_SLOW;
  end

  // One step per sample toward the goal without overshoot.
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      fine <= {hlc_pkg::VOL_MUTE_CODE, 2'b00};
    end
    else if (tick_i)
    begin
      // One spare bit keeps the sums near the mute code from wrapping.
      if ({1'b0, fine} + {1'b0, step} <= {1'b0, goal})
      begin
        fine <= fine + step;
      end
      else if ({1'b0, fine} > {1'b0, goal} + {1'b0, step})
      begin
        fine <= fine - step;
      end
      else
      begin
        fine <= goal;
      end
    end
  end

  assign code_o = fine[9:hlc_pkg::VOL_FINE_SHIFT];
endmodule
`default_nettype wire

// ==== hlc_gain_path.sv ====
// Level control, de-emphasis and output volume path of a stereo DAC.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Either channel over threshold lowers shared gain.
// - Gated changes land at zero cross or timeout.
// - Full-scale overflow applies gain within one sample.
// - Gating off in level control: immediate changes, one-code attenuation.
// - Attenuate while over threshold, repeat on return.
// - Quiet wait period raises gain up to reference.
// - Recovery at wait rate, or at timeout rate.
// - Wait timer cleared between reset and detect levels.
// - Impulse deficit recovers faster by speed field.
// - Level control off means manual per-channel gain.
// - Gain write restarts zero-cross counter unless unchanged.
// - Level control starts from the left gain.
// - Gain writes ignored while level control runs.
// - Enable-selected recursive de-emphasis filter.
// - Output volume 256 codes, half-dB, top code mutes.
// - Volume link makes left field set both.
// - Volume ramps at slow or fast transition rate.
// - Soft mute ramps to zero and back.
// - Releasing mute mid-ramp returns to programmed volume.
module hlc_gain_path (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic sample_valid_i,
  input wire logic [23:0] left_sample_i,
  input wire logic [23:0] right_sample_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic alc_enable_i,
  input wire logic dac_power_enable_i,
  input wire logic zero_cross_gate_disable_i,
  input wire logic [1:0] zero_cross_timeout_sel_i,
  input wire logic [1:0] limiter_step_sel_i,
  input wire logic [1:0] limiter_threshold_sel_i,
  input wire logic [2:0] recovery_wait_sel_i,
  input wire logic [1:0] recovery_step_sel_i,
  input wire logic [7:0] recovery_reference_level_i,
  input wire logic [1:0] fast_recovery_speed_i,
  input wire logic [1:0] deemphasis_sel_i,
  input wire logic [7:0] left_output_volume_i,
  input wire logic [7:0] right_output_volume_i,
  input wire logic volume_link_i,
  input wire logic volume_ramp_time_sel_i,
  input wire logic soft_mute_request_i,
  output logic [23:0] left_out_o,
  output logic [23:0] right_out_o,
  output logic out_valid_o,
  output logic [7:0] level_gain_value_o,
  output logic [7:0] left_internal_gain_o,
  output logic [7:0] right_internal_gain_o
);
  localparam int W = hlc_pkg::SAMPLE_W;

  logic [7:0] left_level_gain;
  logic [7:0] right_level_gain;
  logic [7:0] alc_gain;
  logic alc_run;
  logic alc_run_d;
  logic [14:0] wait_cnt;
  logic over_fs;
  logic restart_left;
  logic restart_right;
  logic gate_now;
  logic [10:0] zc_timeout;
  logic [14:0] wait_period;
  logic [23:0] in_mag [2];
  logic [23:0] peak;
  logic [23:0] limit_level;
  logic [23:0] reset_level;
  logic [7:0] lim_step;
  logic [8:0] rec_step;
  logic [8:0] rec_sum;
  logic caught_up;
  logic [7:0] left_target;
  logic [7:0] right_target;
  logic [7:0] vol_code [2];
  logic signed [W-1:0] stage_a [2];
  logic stage_a_valid;
  logic signed [W-1:0] dem_x1 [2];
  logic signed [W-1:0] dem_y1 [2];
  logic signed [W-1:0] in_s [2];
  logic [7:0] int_gain [2];

  // Saturate a wide signed value to one sample.
  function automatic logic signed [W-1:0] sat(input logic signed [47:0] v);
    logic signed [47:0] hi;
    logic signed [47:0] lo;
    hi = 48'sh0000_007F_FFFF;
    lo = -48'sh0000_0080_0000;
    if (v > hi)
      return hi[W-1:0];
    else if (v < lo)
      return lo[W-1:0];
    else
      return v[W-1:0];
  endfunction

  // Level gain: 16 codes of 0.375 dB per octave around the unity code.
  function automatic logic signed [47:0] level_mul(
    input logic signed [W-1:0] s,
    input logic [7:0] code
  );
    logic signed [9:0] d;
    logic signed [5:0] q;
    logic signed [47:0] p;
    d = $signed({2'b00, code}) -
        $signed({2'b00, hlc_pkg::LEVEL_GAIN_UNITY});
    q = d[9:4];
    p = 48'(s) * $signed({32'h0000_0000, hlc_pkg::LEVEL_MANT[d[3:0]]});
    if (q >= 0)
      p = p <<< q;
    else
      p = p >>> (-q);
    return p >>> hlc_pkg::MANT_FRAC;
  endfunction

  // Output volume: code zero is the boost, 0.5 dB per code, top code mutes.
  function automatic logic signed [W-1:0] vol_mul(
    input logic signed [W-1:0] s,
    input logic [7:0] code
  );
    logic [4:0] q;
    logic [3:0] r;
    logic signed [47:0] p;
    q = 5'(code / 8'(hlc_pkg::VOL_CODES_PER_OCT));
    r = 4'(code % 8'(hlc_pkg::VOL_CODES_PER_OCT));
    p = 48'(s) * $signed({32'h0000_0000, hlc_pkg::VOL_MANT[r]});
    p = p >>> (hlc_pkg::MANT_FRAC - hlc_pkg::VOL_BOOST_SHIFT + int'(q));
    if (code == hlc_pkg::VOL_MUTE_CODE)
      return '0;
    else
      return sat(p);
  endfunction

  // Level control runs only while enabled and the DAC is powered.
  assign alc_run = alc_enable_i && dac_power_enable_i;
  assign in_s[0] = $signed(left_sample_i);
  assign in_s[1] = $signed(right_sample_i);
  assign int_gain[0] = left_internal_gain_o;
  assign int_gain[1] = right_internal_gain_o;

  // Detection quantities, step sizes and timer periods.
  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      in_mag[c] = in_s[c][W-1] ? 24'(-in_s[c]) : 24'(in_s[c]);
    end
    peak = (in_mag[0] > in_mag[1]) ? in_mag[0] : in_mag[1];
    limit_level = hlc_pkg::LIMIT_LEVEL[limiter_threshold_sel_i];
    reset_level = limit_level - (limit_level >> hlc_pkg::RESET_LEVEL_SHIFT);
    lim_step = zero_cross_gate_disable_i ? 8'h01 :
               8'({6'h00, limiter_step_sel_i} + 8'h01);
    rec_step = 9'({7'h00, recovery_step_sel_i} + 9'h001);
    if ({1'b0, alc_gain} + hlc_pkg::FAST_GAP <
        {1'b0, recovery_reference_level_i})
    begin
      rec_step = 9'(rec_step << ({1'b0, fast_recovery_speed_i} +
                                 3'd1));
    end
    rec_sum = {1'b0, alc_gain} + rec_step;
    zc_timeout = 11'(hlc_pkg::ZC_TIMEOUT_BASE << zero_cross_timeout_sel_i);
    wait_period = 15'(hlc_pkg::WAIT_BASE << recovery_wait_sel_i);
    caught_up = (left_internal_gain_o == alc_gain) &&
                (right_internal_gain_o == alc_gain);
  end

  // Manual gain registers; writes are dropped while level control runs.
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      left_level_gain <= hlc_pkg::LEVEL_GAIN_UNITY;
      right_level_gain <= hlc_pkg::LEVEL_GAIN_UNITY;
    end
    else if (reg_wr_i && !alc_run)
    begin
      if (reg_addr_i == hlc_pkg::ADDR_LEFT_GAIN)
        left_level_gain <= reg_wdata_i;
      if (reg_addr_i == hlc_pkg::ADDR_RIGHT_GAIN)
        right_level_gain <= reg_wdata_i;
    end
  end

  // A write of a new value restarts that channel's zero-cross counter.
  assign restart_left = reg_wr_i && !alc_run &&
                        reg_addr_i == hlc_pkg::ADDR_LEFT_GAIN &&
                        reg_wdata_i != left_level_gain;
  assign restart_right = reg_wr_i && !alc_run &&
                         reg_addr_i == hlc_pkg::ADDR_RIGHT_GAIN &&
                         reg_wdata_i != right_level_gain;

  // Registered read data; unmapped addresses read zero.
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      reg_rdata_o <= 8'h00;
    else if (reg_addr_i == hlc_pkg::ADDR_LEFT_GAIN)
      reg_rdata_o <= left_level_gain;
    else if (reg_addr_i == hlc_pkg::ADDR_RIGHT_GAIN)
      reg_rdata_o <= right_level_gain;
    else
      reg_rdata_o <= 8'h00;
  end

  // Shared level control gain: limiter, recovery wait and recovery.
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      alc_gain <= hlc_pkg::LEVEL_GAIN_UNITY;
      alc_run_d <= 1'b0;
      wait_cnt <= 15'h0000;
    end
    else
    begin
      alc_run_d <= alc_run;
      if (alc_run && !alc_run_d)
      begin
        alc_gain <= left_level_gain;
        wait_cnt <= 15'h0000;
      end
      else if (alc_run && sample_valid_i)
      begin
        if (peak > limit_level)
        begin
          wait_cnt <= 15'h0000;
          if (caught_up || zero_cross_gate_disable_i)
          begin
            alc_gain <= (alc_gain > lim_step) ? alc_gain - lim_step :
                        8'h00;
          end
        end
        else if (peak >= reset_level)
        begin
          wait_cnt <= 15'h0000;
        end
        else if (wait_cnt + 15'h0001 >= wait_period)
        begin
          if (caught_up)
          begin
            wait_cnt <= 15'h0000;
            if (alc_gain < recovery_reference_level_i)
            begin
              alc_gain <= (rec_sum > {1'b0, recovery_reference_level_i}) ?
                          recovery_reference_level_i : rec_sum[7:0];
            end
          end
        end
        else
        begin
          wait_cnt <= wait_cnt + 15'h0001;
        end
      end
    end
  end

  // Targets: shared gain in level control, manual fields otherwise.
  assign left_target = alc_run ? alc_gain : left_level_gain;
  assign right_target = alc_run ? alc_gain : right_level_gain;
  assign level_gain_value_o = alc_run ? alc_gain : left_level_gain;
  assign gate_now = over_fs ||
                    (alc_run && zero_cross_gate_disable_i);

  hlc_zc_gate u_left_gate (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .tick_i(sample_valid_i),
    .sample_sign_i(left_sample_i[W-1]),
    .target_i(left_target),
    .restart_i(restart_left),
    .immediate_i(gate_now),
    .timeout_i(zc_timeout),
    .gain_o(left_internal_gain_o)
  );

  hlc_zc_gate u_right_gate (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .tick_i(sample_valid_i),
    .sample_sign_i(right_sample_i[W-1]),
    .target_i(right_target),
    .restart_i(restart_right),
    .immediate_i(gate_now),
    .timeout_i(zc_timeout),
    .gain_o(right_internal_gain_o)
  );

  // Stage one: level gain, full-scale flag and de-emphasis per sample.
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      over_fs <= 1'b0;
      stage_a_valid <= 1'b0;
      for (int c = 0; c < 2; c++)
      begin
        stage_a[c] <= '0;
        dem_x1[c] <= '0;
        dem_y1[c] <= '0;
      end
    end
    else
    begin
      stage_a_valid <= sample_valid_i;
      if (sample_valid_i)
      begin
        logic signed [47:0] g [2];
        logic signed [W-1:0] x [2];
        logic signed [47:0] acc;
        logic ovf;
        ovf = 1'b0;
        for (int c = 0; c < 2; c++)
        begin
          g[c] = level_mul(in_s[c], int_gain[c]);
          x[c] = sat(g[c]);
          ovf = ovf || (48'(x[c]) != g[c]);
          acc = 48'(x[c]) * 48'(hlc_pkg::DEEMPH_B0) +
                48'(dem_x1[c]) * 48'(hlc_pkg::DEEMPH_B1) +
                48'(dem_y1[c]) * 48'(hlc_pkg::DEEMPH_A1);
          dem_x1[c] <= x[c];
          if (deemphasis_sel_i == hlc_pkg::DEEMPH_ON)
          begin
            dem_y1[c] <= sat(acc >>> hlc_pkg::MANT_FRAC);
            stage_a[c] <= sat(acc >>> hlc_pkg::MANT_FRAC);
          end
          else
          begin
            dem_y1[c] <= x[c];
            stage_a[c] <= x[c];
          end
        end
        over_fs <= ovf;
      end
    end
  end

  // Output volume ramps, one per channel, linked on request.
  hlc_vol_ramp u_left_ramp (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .tick_i(sample_valid_i),
    .target_code_i(left_output_volume_i),
    .mute_i(soft_mute_request_i),
    .fast_i(volume_ramp_time_sel_i),
    .code_o(vol_code[0])
  );

  hlc_vol_ramp u_right_ramp (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .tick_i(sample_valid_i),
    .target_code_i(volume_link_i ? left_output_volume_i :
                   right_output_volume_i),
    .mute_i(soft_mute_request_i),
    .fast_i(volume_ramp_time_sel_i),
    .code_o(vol_code[1])
  );

  // Stage two: output volume and the registered output samples.
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      left_out_o <= 24'h00_0000;
      right_out_o <= 24'h00_0000;
      out_valid_o <= 1'b0;
    end
    else
    begin
      out_valid_o <= stage_a_valid;
      if (stage_a_valid)
      begin
        left_out_o <= vol_mul(stage_a[0], vol_code[0]);
        right_out_o <= vol_mul(stage_a[1], vol_code[1]);
      end
    end
  end
endmodule
`default_nettype wire

// ==== hlc_gain_path_asserts.sv ====
// Port-level checker of the gain path, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module hlc_gain_path_asserts (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic sample_valid_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic alc_enable_i,
  input wire logic dac_power_enable_i,
  input wire logic zero_cross_gate_disable_i,
  input wire logic [7:0] recovery_reference_level_i,
  input wire logic soft_mute_request_i,
  input wire logic [23:0] left_out_o,
  input wire logic [23:0] right_out_o,
  input wire logic out_valid_o,
  input wire logic [7:0] level_gain_value_o,
  input wire logic [7:0] left_internal_gain_o,
  input wire logic [7:0] right_internal_gain_o
);
  logic run;
  logic [10:0] mcnt;
  // Level control only runs while the DAC is powered.
  assign run = alc_enable_i & dac_power_enable_i;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);
  // Counts samples taken while soft mute stays requested, saturating.
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || !soft_mute_request_i)
      mcnt <= 11'h000;
    else if (sample_valid_i && mcnt != 11'h7FF)
      mcnt <= mcnt + 11'h001;
  end
  a_out_latency: assert property (
    sample_valid_i |-> ##2 out_valid_o)
    else $error("output pulse missing two cycles after a sample");
  a_out_cause: assert property (
    out_valid_o |-> $past(sample_valid_i, 2))
    else $error("output pulse without a sample two cycles before");
  a_out_hold: assert property (
    !out_valid_o |-> $stable(left_out_o) && $stable(right_out_o))
    else $error("output samples moved between output pulses");
  a_gain_tick: assert property (
    $changed(left_internal_gain_o) || $changed(right_internal_gain_o)
    |-> $past(sample_valid_i) || $past(sample_valid_i, 2))
    else $error("internal gain moved away from a sample boundary");
  a_limit_one_step: assert property (
    run && zero_cross_gate_disable_i && $past(run) && $past(run, 2)
    && $past(zero_cross_gate_disable_i)
    && level_gain_value_o < $past(level_gain_value_o)
    |-> $past(level_gain_value_o) - level_gain_value_o == 8'h01)
    else $error("ungated limiter stepped by more than one code");
  a_gain_ceiling: assert property (
    run && $past(run) && $past(run, 2)
    && level_gain_value_o > $past(level_gain_value_o)
    |-> level_gain_value_o <= recovery_reference_level_i)
    else $error("recovery raised the gain above the reference");
  a_manual_view: assert property (
    !run && $past(!run) && !$past(srst_i)
    && $past(reg_addr_i) == hlc_pkg::ADDR_LEFT_GAIN
    |-> reg_rdata_o == $past(level_gain_value_o))
    else $error("manual gain value differs from the left register");
  a_write_taken: assert property (
    (reg_wr_i && !run && reg_addr_i == hlc_pkg::ADDR_RIGHT_GAIN
    ##1 reg_addr_i == hlc_pkg::ADDR_RIGHT_GAIN)
    |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("stopped write did not reach the right register");
  a_write_refused: assert property (
    $past(run) && $past(run, 2) && !$past(srst_i) && !$past(srst_i, 2)
    && $past(reg_addr_i) == hlc_pkg::ADDR_LEFT_GAIN
    && $past(reg_addr_i, 2) == hlc_pkg::ADDR_LEFT_GAIN
    |-> $stable(reg_rdata_o))
    else $error("left register changed while level control ran");
  a_mute_silent: assert property (
    out_valid_o && mcnt > 11'h3FE
    |-> left_out_o == '0 && right_out_o == '0)
    else $error("output not silent after a full soft mute ramp");
  c_limit: cover property (run &&
    level_gain_value_o < $past(level_gain_value_o));
  c_refused: cover property (run && reg_wr_i);
  c_muted: cover property (mcnt == 11'h406);
endmodule
bind hlc_gain_path hlc_gain_path_asserts u_chk (.*);
`default_nettype wire

// ==== hlc_host_model.sv ====
// Host model that delivers stereo samples once per sample period.
`timescale 1ns/1ps
`default_nettype none
module hlc_host_model #(
  parameter int PERIOD = 8
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [23:0] amp_i,
  input wire logic alt_i,
  output logic sample_valid_o,
  output logic [23:0] left_sample_o,
  output logic [23:0] right_sample_o
);
  int cnt;
  logic neg;
  logic [23:0] val;
  // Alternating signs give a zero crossing at every sample.
  assign val = neg ? (~amp_i + 24'h00_0001) : amp_i;
  // Idle values at time zero.
  initial
  begin
    sample_valid_o = 1'b0;
    left_sample_o = '0;
    right_sample_o = '0;
    cnt = 0;
    neg = 1'b0;
  end
  // Between pulses the sample lines toggle, so stale data is never usable.
  always @(posedge core_clk_i)
  begin
    #2;
    sample_valid_o = !srst_i && cnt == PERIOD - 1;
    left_sample_o = sample_valid_o ? val : ~left_sample_o;
    right_sample_o = sample_valid_o ? val : ~right_sample_o;
    cnt = (srst_i || sample_valid_o) ? 0 : cnt + 1;
    neg = srst_i ? 1'b0 : (sample_valid_o ? alt_i & ~neg : neg);
  end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench of the level control and output volume path.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [7:0] AL = hlc_pkg::ADDR_LEFT_GAIN;
  localparam logic [7:0] AR = hlc_pkg::ADDR_RIGHT_GAIN;
  localparam logic [23:0] AMP = 24'h10_0000;
  logic core_clk_i, srst_i, wr, alc, gd, link, fast, mute, alt, sv, ov, pwr;
  logic [7:0] addr, wdata, ref_lvl, lvol, rvol, rdata, lgain, igl, igr;
  logic [1:0] rstep, thr, dem;
  logic [23:0] amp, ls, rs, lo, ro;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  hlc_host_model #(.PERIOD(8)) host (.core_clk_i(core_clk_i),
    .srst_i(srst_i), .amp_i(amp), .alt_i(alt), .sample_valid_o(sv),
    .left_sample_o(ls), .right_sample_o(rs));
  hlc_gain_path DUT (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .sample_valid_i(sv), .left_sample_i(ls), .right_sample_i(rs),
    .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .alc_enable_i(alc), .dac_power_enable_i(pwr),
    .zero_cross_gate_disable_i(gd), .zero_cross_timeout_sel_i(2'b00),
    .limiter_step_sel_i(2'b00), .limiter_threshold_sel_i(thr),
    .recovery_wait_sel_i(3'b000), .recovery_step_sel_i(rstep),
    .recovery_reference_level_i(ref_lvl), .fast_recovery_speed_i(2'b00),
    .deemphasis_sel_i(dem), .left_output_volume_i(lvol),
    .right_output_volume_i(rvol), .volume_link_i(link),
    .volume_ramp_time_sel_i(fast), .soft_mute_request_i(mute),
    .left_out_o(lo), .right_out_o(ro), .out_valid_o(ov),
    .level_gain_value_o(lgain), .left_internal_gain_o(igl),
    .right_internal_gain_o(igr));
  // Free-running 40 MHz clock.
  initial
  begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  // Cuts a hung run short.
  always @(posedge core_clk_i)
  begin
    cyc = cyc + 1;
    if (cyc == 50000)
    begin
      n_errors = n_errors + 1;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [23:0] seen, exp);
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      n_errors = n_errors + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk_i);
    #2;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge sv);
    step(1);
  endtask
  task automatic wr_reg(input logic [7:0] a, d);
    step(1);
    addr = a;
    wdata = d;
    wr = 1'b1;
    step(1);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, exp);
    step(1);
    addr = a;
    step(1);
    check("reg_rdata", rdata, exp);
  endtask
  // Main sequence: manual gain, level control, then volume and mute.
  initial
  begin
    srst_i = 1'b1;
    {wr, alc, gd, fast, mute, alt} = '0;
    {link, pwr} = 2'b11;
    {addr, wdata, thr, dem} = '0;
    rstep = 2'b11;
    ref_lvl = 8'h48;
    lvol = 8'h18;
    rvol = 8'hFF;
    amp = AMP;
    step(6);
    srst_i = 1'b0;
    rd_reg(AL, 8'h91);
    rd_reg(AR, 8'h91);
    wr_reg(AL, 8'h80);
    wr_reg(AR, 8'hA0);
    rd_reg(AR, 8'hA0);
    ticks(140);
    check("left_gain", igl, 8'h80);
    check("right_gain", igr, 8'hA0);
    wr_reg(AL, 8'h70);
    ticks(100);
    wr_reg(AL, 8'h70);
    ticks(35);
    check("left_gain", igl, 8'h70);
    wr_reg(AL, 8'h60);
    ticks(100);
    wr_reg(AL, 8'h50);
    ticks(35);
    check("left_gain", igl, 8'h70);
    ticks(100);
    check("left_gain", igl, 8'h50);
    alt = 1'b1;
    wr_reg(AL, 8'h58);
    ticks(3);
    check("left_gain", igl, 8'h58);
    amp = 24'h00_1000;
    gd = 1'b1;
    alc = 1'b1;
    ticks(10);
    check("right_gain", igr, 8'h58);
    amp = 24'h70_0000;
    ticks(20);
    check("right_gain", igr, 8'h45);
    check("left_gain", igl, 8'h45);
    check("level_gain", lgain, 8'h44);
    wr_reg(AL, 8'h20);
    rd_reg(AL, 8'h58);
    amp = 24'h00_1000;
    ticks(300);
    check("level_gain", lgain, ref_lvl);
    alc = 1'b0;
    ticks(140);
    check("left_gain", igl, 8'h58);
    alt = 1'b0;
    amp = AMP;
    wr_reg(AL, 8'h91);
    wr_reg(AR, 8'h91);
    ticks(140);
    check("left_out", lo, AMP);
    check("right_out", ro, AMP);
    mute = 1'b1;
    ticks(100);
    mute = 1'b0;
    ticks(1030);
    check("left_out", lo, AMP);
    mute = 1'b1;
    ticks(1030);
    check("left_out", lo, 24'h00_0000);
    fast = 1'b1;
    mute = 1'b0;
    ticks(260);
    check("left_out", lo, AMP);
    link = 1'b0;
    lvol = 8'hFF;
    rvol = 8'h30;
    ticks(260);
    check("left_out", lo, 24'h00_0000);
    check("right_out", ro, 24'h04_0000);
    // A saturating gain makes the next manual change land at once.
    wr_reg(AL, 8'hFF);
    ticks(140);
    wr_reg(AL, 8'h91);
    ticks(2);
    check("left_gain", igl, 8'h91);
    final_report();
  end
endmodule
`default_nettype wire
